/* File: hdl/mad_pkg.sv */
/*
  Shared constants and types of the motion activity detector: clock and
  sample rates, register offsets, field positions and reset values.
  Assumes a 40 MHz system clock and a 32-bit classic Wishbone slave.
*/
`default_nettype none

package mad_pkg;

  // Clock and sample rates
  localparam int CLK_HZ = 40_000_000;
  localparam int ODR_MAX_HZ = 400;
  localparam int WAKE_HZ = 6;
  localparam int DIV_ODR_MAX = CLK_HZ / ODR_MAX_HZ;
  localparam int DIV_WAKE = CLK_HZ / WAKE_HZ;
  // Rate code 0 is 400 Hz halved five times, 12.5 Hz
  localparam int ODR_STEPS = 5;
  localparam int DIVW = 24;

  // Sample width
  localparam int SW = 12;

  typedef enum logic [1:0] {MAD_STANDBY, MAD_MEASURE, MAD_WAKEUP} mad_mode_e;
  typedef enum logic [1:0] {MAD_LINK_DEFAULT, MAD_LINK_LINKED, MAD_LINK_LOOP}
    mad_link_e;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_ACT_THR = 8'h04;
  localparam logic [7:0] ADR_ACT_TIME = 8'h08;
  localparam logic [7:0] ADR_INACT_THR = 8'h0C;
  localparam logic [7:0] ADR_INACT_TIME = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_DATA_X = 8'h18;
  localparam logic [7:0] ADR_DATA_Y = 8'h1C;
  localparam logic [7:0] ADR_DATA_Z = 8'h20;

  // Control register fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_NOISE = 2;
  localparam int CTRL_RANGE = 4;
  localparam int CTRL_ODR = 6;
  localparam int CTRL_ACT_EN = 9;
  localparam int CTRL_ACT_REF = 10;
  localparam int CTRL_INACT_EN = 11;
  localparam int CTRL_INACT_REF = 12;
  localparam int CTRL_LINK = 13;
  localparam int CTRL_AUTOSLEEP = 15;
  localparam int CTRL_ACT_INT = 16;
  localparam int CTRL_INACT_INT = 17;

  // Status register fields
  localparam int STAT_ACT = 0;
  localparam int STAT_INACT = 1;
  localparam int STAT_AWAKE = 2;
  localparam int STAT_DRDY = 3;

  // Values after reset, and the last valid rate code
  localparam logic [2:0] ODR_RST = 3'h3;
  localparam logic [2:0] ODR_LAST = 3'h5;
  localparam logic [7:0] ACT_TIME_RST = 8'h00;
  localparam logic [15:0] INACT_TIME_RST = 16'h0000;

endpackage

`default_nettype wire

/* File: hdl/mad_smp_if.sv */
/*
  Carrier for one three-axis acceleration sample inside the detector.
  Assumes the top module drives it and the comparators only read it.
*/
`default_nettype none

interface mad_smp_if;
  logic valid;
  logic signed [mad_pkg::SW-1:0] x;
  logic signed [mad_pkg::SW-1:0] y;
  logic signed [mad_pkg::SW-1:0] z;
  modport src (output valid, x, y, z);
  modport dst (input valid, x, y, z);
endinterface

`default_nettype wire

/* File: hdl/mad_rate_gen.sv */
/*
  Sample request generator: one strobe per output sample period.
  Assumes the caller only presents rate codes up to 5.
*/
`default_nettype none

module mad_rate_gen #(
  parameter int P_DIV_ODR_MAX = mad_pkg::DIV_ODR_MAX,
  parameter int P_DIV_WAKE = mad_pkg::DIV_WAKE
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Mode and rate
  input wire mad_pkg::mad_mode_e i_mode,
  input wire logic [2:0] i_odr,
  // Sample request strobe
  output logic o_tick
);
  localparam int W = mad_pkg::DIVW;

  typedef struct packed {
    logic [W-1:0] cnt;
    mad_pkg::mad_mode_e mode;
    logic [2:0] odr;
    logic tick;
  } mad_rg_s;

  mad_rg_s s;
  mad_rg_s next_s;
  logic [W-1:0] last;

  always_comb
  begin
    if (i_mode == mad_pkg::MAD_WAKEUP)
      last = W'(P_DIV_WAKE - 1);
    else
      last = W'((P_DIV_ODR_MAX << (mad_pkg::ODR_STEPS - int'(i_odr))) - 1);
    next_s = s;
    next_s.mode = i_mode;
    next_s.odr = i_odr;
    next_s.tick = 1'b0;
    // A rate or mode change restarts the period so no short one slips out
    if (i_mode == mad_pkg::MAD_STANDBY || i_mode != s.mode || i_odr != s.odr)
      next_s.cnt = '0;
    else if (s.cnt >= last)
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_tick = s.tick;
endmodule

`default_nettype wire

/* File: hdl/mad_axis_cmp.sv */
/*
  Three-axis threshold comparator, absolute or against a reference.
  Assumes a sample arrives on the carrier; purely combinational.
*/
`default_nettype none

module mad_axis_cmp (
  // Sample
  mad_smp_if.dst smp,
  // Reference and threshold
  input wire logic i_use_ref,
  input wire logic signed [mad_pkg::SW-1:0] i_ref_x,
  input wire logic signed [mad_pkg::SW-1:0] i_ref_y,
  input wire logic signed [mad_pkg::SW-1:0] i_ref_z,
  input wire logic [mad_pkg::SW-1:0] i_thr,
  // Results, valid with the sample
  output logic o_over_any,
  output logic o_within_all
);
  localparam int W = mad_pkg::SW + 1;

  function automatic logic [W-1:0] mag(
    input logic signed [W-2:0] a,
    input logic signed [W-2:0] r,
    input logic use_ref
  );
    logic signed [W-1:0] d;
    d = use_ref ? W'(a) - W'(r) : W'(a);
    mag = d[W-1] ? W'(-d) : d;
  endfunction

  logic [W-1:0] mx;
  logic [W-1:0] my;
  logic [W-1:0] mz;
  logic [W-1:0] thr;

  always_comb
  begin
    mx = mag(smp.x, i_ref_x, i_use_ref);
    my = mag(smp.y, i_ref_y, i_use_ref);
    mz = mag(smp.z, i_ref_z, i_use_ref);
    thr = {1'b0, i_thr};
    o_over_any = smp.valid && (mx > thr || my > thr || mz > thr);
    o_within_all = smp.valid && mx <= thr && my <= thr && mz <= thr;
  end
endmodule

`default_nettype wire

/* File: hdl/mad_top.sv */
/*
  Motion activity detector: operating modes, noise and range selection,
  activity and inactivity detection, awake state and Wishbone registers.
  Assumes the sensor front end answers each sample request with one
  valid sample a few clocks later and applies noise mode and range itself.
*/
`default_nettype none

// What this block does
// - Three operating modes, standby, measurement and wake-up, chosen by the host.
// - Standby stops sampling and processing; pending data and flags are kept.
// - Reset leaves the block in standby with all sensing functions off.
// - Measurement samples continuously at 12.5 Hz to 400 Hz, all features on.
// - Wake-up mode samples six times per second.
// - Wake-up keeps all features but the activity timer; data stays readable.
// - Samples are 12 bits; range is selectable among 2, 4 and 8 g.
// - Normal, low noise and ultralow noise modes are selectable.
// - Each event sets a status flag and may raise the interrupt.
// - An awake flag tells moving from stationary.
// - Detection works in measurement and wake-up modes.
// - Activity needs the threshold exceeded for the whole activity time.
// - Absolute activity compares raw samples, gravity included.
// - Referenced activity takes the first engaged sample as reference.
// - Inactivity needs samples under threshold for the whole inactivity time.
// - Absolute inactivity compares raw samples throughout the inactivity time.
// - Referenced inactivity references the first sample after becoming awake.
// - A sample outside the band becomes the new reference; count restarts.
// - Staying inside the band long enough makes the block asleep.
// - Linked mode arms one detector at a time, after the host clears flags.
// - Loop mode alternates detectors without waiting for the host.
// - Autosleep, in linked or loop mode only, switches to wake-up on inactivity, measurement on activity.
module mad_top #(
  parameter int P_DIV_ODR_MAX = mad_pkg::DIV_ODR_MAX,
  parameter int P_DIV_WAKE = mad_pkg::DIV_WAKE
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Sensor front end
  output logic o_smp_req,
  input wire logic i_smp_valid,
  input wire logic signed [mad_pkg::SW-1:0] i_smp_x,
  input wire logic signed [mad_pkg::SW-1:0] i_smp_y,
  input wire logic signed [mad_pkg::SW-1:0] i_smp_z,
  output logic [1:0] o_noise_mode,
  output logic [1:0] o_range,
  // Status outputs
  output logic o_awake,
  output logic o_int
);
  localparam int SW = mad_pkg::SW;

  typedef struct packed {
    mad_pkg::mad_mode_e mode;
    logic [1:0] noise;
    logic [1:0] range;
    logic [2:0] odr;
    logic act_en;
    logic act_ref;
    logic inact_en;
    logic inact_ref;
    mad_pkg::mad_link_e link;
    logic autosleep;
    logic act_int;
    logic inact_int;
    logic [SW-1:0] act_thr;
    logic [7:0] act_time;
    logic [SW-1:0] inact_thr;
    logic [15:0] inact_time;
    logic st_act;
    logic st_inact;
    logic awake;
    logic drdy;
    logic [3*SW-1:0] data;
    logic [3*SW-1:0] aref;
    logic aref_ok;
    logic [3*SW-1:0] iref;
    logic iref_ok;
    logic [7:0] act_cnt;
    logic [15:0] inact_cnt;
    logic ack;
    logic [31:0] rdat;
    logic irq;
  } mad_top_s;

  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    for (int b = 0; b < 4; b++)
      wmerge[8*b +: 8] = sel[b] ? wd[8*b +: 8] : old[8*b +: 8];
  endfunction

  function automatic logic [31:0] sext(input logic [SW-1:0] v);
    sext = {{(32-SW){v[SW-1]}}, v};
  endfunction

  mad_top_s s;
  mad_top_s next_s;
  logic tick;
  logic take;
  logic act_over;
  logic inact_in;
  logic act_armed;
  logic inact_armed;
  logic wb_req;
  logic [31:0] ctrl_rd;
  logic [31:0] wv;
  logic [7:0] act_need;
  logic [15:0] inact_need;
  logic link_on;

  mad_smp_if smp ();

  // Standby samples are dropped so that pending results stay as they are
  assign take = i_smp_valid && s.mode != mad_pkg::MAD_STANDBY;
  assign smp.valid = take;
  assign smp.x = i_smp_x;
  assign smp.y = i_smp_y;
  assign smp.z = i_smp_z;

  mad_rate_gen #(
    .P_DIV_ODR_MAX(P_DIV_ODR_MAX),
    .P_DIV_WAKE(P_DIV_WAKE)
  ) u_rate (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_mode(s.mode),
    .i_odr(s.odr),
    .o_tick(tick)
  );

  mad_axis_cmp u_act_cmp (
    .smp(smp),
    .i_use_ref(s.act_ref),
    .i_ref_x(s.aref[SW-1:0]),
    .i_ref_y(s.aref[2*SW-1:SW]),
    .i_ref_z(s.aref[3*SW-1:2*SW]),
    .i_thr(s.act_thr),
    .o_over_any(act_over),
    .o_within_all()
  );

  mad_axis_cmp u_inact_cmp (
    .smp(smp),
    .i_use_ref(s.inact_ref),
    .i_ref_x(s.iref[SW-1:0]),
    .i_ref_y(s.iref[2*SW-1:SW]),
    .i_ref_z(s.iref[3*SW-1:2*SW]),
    .i_thr(s.inact_thr),
    .o_over_any(),
    .o_within_all(inact_in)
  );

  always_comb
  begin
    link_on = s.link != mad_pkg::MAD_LINK_DEFAULT;
    // Linked mode waits for the host to clear the last event's flag
    act_armed = s.act_en && (!link_on || (!s.awake &&
      (s.link == mad_pkg::MAD_LINK_LOOP || !s.st_inact)));
    inact_armed = s.inact_en && (!link_on || (s.awake &&
      (s.link == mad_pkg::MAD_LINK_LOOP || !s.st_act)));
    // No activity timer in wake-up: a single sample decides
    if (s.mode == mad_pkg::MAD_WAKEUP || s.act_time == '0)
      act_need = 8'h01;
    else
      act_need = s.act_time;
    inact_need = (s.inact_time == '0) ? 16'h0001 : s.inact_time;
    wb_req = i_wb_cyc && i_wb_stb && !s.ack;
    ctrl_rd = '0;
    ctrl_rd[mad_pkg::CTRL_MODE +: 2] = s.mode;
    ctrl_rd[mad_pkg::CTRL_NOISE +: 2] = s.noise;
    ctrl_rd[mad_pkg::CTRL_RANGE +: 2] = s.range;
    ctrl_rd[mad_pkg::CTRL_ODR +: 3] = s.odr;
    ctrl_rd[mad_pkg::CTRL_ACT_EN] = s.act_en;
    ctrl_rd[mad_pkg::CTRL_ACT_REF] = s.act_ref;
    ctrl_rd[mad_pkg::CTRL_INACT_EN] = s.inact_en;
    ctrl_rd[mad_pkg::CTRL_INACT_REF] = s.inact_ref;
    ctrl_rd[mad_pkg::CTRL_LINK +: 2] = s.link;
    ctrl_rd[mad_pkg::CTRL_AUTOSLEEP] = s.autosleep;
    ctrl_rd[mad_pkg::CTRL_ACT_INT] = s.act_int;
    ctrl_rd[mad_pkg::CTRL_INACT_INT] = s.inact_int;
    wv = '0;

    next_s = s;
    next_s.ack = wb_req;
    next_s.rdat = '0;

    // Register reads
    if (wb_req && !i_wb_we)
    begin
      unique case (i_wb_adr)
        mad_pkg::ADR_CTRL: next_s.rdat = ctrl_rd;
        mad_pkg::ADR_ACT_THR: next_s.rdat = 32'(s.act_thr);
        mad_pkg::ADR_ACT_TIME: next_s.rdat = 32'(s.act_time);
        mad_pkg::ADR_INACT_THR: next_s.rdat = 32'(s.inact_thr);
        mad_pkg::ADR_INACT_TIME: next_s.rdat = 32'(s.inact_time);
        mad_pkg::ADR_STATUS:
          next_s.rdat = 32'({s.drdy, s.awake, s.st_inact, s.st_act});
        mad_pkg::ADR_DATA_X: next_s.rdat = sext(s.data[SW-1:0]);
        mad_pkg::ADR_DATA_Y: next_s.rdat = sext(s.data[2*SW-1:SW]);
        mad_pkg::ADR_DATA_Z: next_s.rdat = sext(s.data[3*SW-1:2*SW]);
        default: next_s.rdat = '0;
      endcase
    end

    // Register writes; reserved codes leave the field as it was
    if (wb_req && i_wb_we)
    begin
      unique case (i_wb_adr)
        mad_pkg::ADR_CTRL:
        begin
          wv = wmerge(ctrl_rd, i_wb_dat, i_wb_sel);
          if (wv[mad_pkg::CTRL_MODE +: 2] != 2'h3)
            next_s.mode = mad_pkg::mad_mode_e'(wv[mad_pkg::CTRL_MODE +: 2]);
          if (wv[mad_pkg::CTRL_NOISE +: 2] != 2'h3)
            next_s.noise = wv[mad_pkg::CTRL_NOISE +: 2];
          if (wv[mad_pkg::CTRL_RANGE +: 2] != 2'h3)
            next_s.range = wv[mad_pkg::CTRL_RANGE +: 2];
          if (wv[mad_pkg::CTRL_ODR +: 3] <= mad_pkg::ODR_LAST)
            next_s.odr = wv[mad_pkg::CTRL_ODR +: 3];
          next_s.act_en = wv[mad_pkg::CTRL_ACT_EN];
          next_s.act_ref = wv[mad_pkg::CTRL_ACT_REF];
          next_s.inact_en = wv[mad_pkg::CTRL_INACT_EN];
          next_s.inact_ref = wv[mad_pkg::CTRL_INACT_REF];
          if (wv[mad_pkg::CTRL_LINK +: 2] != 2'h3)
            next_s.link = mad_pkg::mad_link_e'(wv[mad_pkg::CTRL_LINK +: 2]);
          next_s.autosleep = wv[mad_pkg::CTRL_AUTOSLEEP];
          next_s.act_int = wv[mad_pkg::CTRL_ACT_INT];
          next_s.inact_int = wv[mad_pkg::CTRL_INACT_INT];
        end
        mad_pkg::ADR_ACT_THR:
        begin
          wv = wmerge(32'(s.act_thr), i_wb_dat, i_wb_sel);
          next_s.act_thr = wv[SW-1:0];
        end
        mad_pkg::ADR_ACT_TIME:
        begin
          wv = wmerge(32'(s.act_time), i_wb_dat, i_wb_sel);
          next_s.act_time = wv[7:0];
        end
        mad_pkg::ADR_INACT_THR:
        begin
          wv = wmerge(32'(s.inact_thr), i_wb_dat, i_wb_sel);
          next_s.inact_thr = wv[SW-1:0];
        end
        mad_pkg::ADR_INACT_TIME:
        begin
          wv = wmerge(32'(s.inact_time), i_wb_dat, i_wb_sel);
          next_s.inact_time = wv[15:0];
        end
        mad_pkg::ADR_STATUS:
        begin
          // Write one to clear; events below override in the same cycle
          wv = wmerge(32'h0000_0000, i_wb_dat, i_wb_sel);
          if (wv[mad_pkg::STAT_ACT])
            next_s.st_act = 1'b0;
          if (wv[mad_pkg::STAT_INACT])
            next_s.st_inact = 1'b0;
          if (wv[mad_pkg::STAT_DRDY])
            next_s.drdy = 1'b0;
        end
        default: wv = '0;
      endcase
    end

    // Sample capture, in measurement and wake-up alike
    if (take)
    begin
      next_s.data = {i_smp_z, i_smp_y, i_smp_x};
      next_s.drdy = 1'b1;
    end

    // Inactivity detector
    if (!inact_armed)
    begin
      next_s.iref_ok = 1'b0;
      next_s.inact_cnt = '0;
    end
    else if (take)
    begin
      if (s.inact_ref && !s.iref_ok)
      begin
        next_s.iref = {i_smp_z, i_smp_y, i_smp_x};
        next_s.iref_ok = 1'b1;
        next_s.inact_cnt = '0;
      end
      else if (!inact_in)
      begin
        next_s.inact_cnt = '0;
        if (s.inact_ref)
          next_s.iref = {i_smp_z, i_smp_y, i_smp_x};
      end
      else if (s.inact_cnt + 16'h0001 >= inact_need)
      begin
        next_s.inact_cnt = '0;
        next_s.st_inact = 1'b1;
        next_s.awake = 1'b0;
        next_s.iref_ok = 1'b0;
        if (link_on && s.autosleep)
          next_s.mode = mad_pkg::MAD_WAKEUP;
      end
      else
        next_s.inact_cnt = s.inact_cnt + 16'h0001;
    end

    // Activity detector; on a shared sample activity has the last word
    if (!act_armed)
    begin
      next_s.aref_ok = 1'b0;
      next_s.act_cnt = '0;
    end
    else if (take)
    begin
      if (s.act_ref && !s.aref_ok)
      begin
        next_s.aref = {i_smp_z, i_smp_y, i_smp_x};
        next_s.aref_ok = 1'b1;
        next_s.act_cnt = '0;
      end
      else if (!act_over)
        next_s.act_cnt = '0;
      else if (s.act_cnt + 8'h01 >= act_need)
      begin
        next_s.act_cnt = '0;
        next_s.st_act = 1'b1;
        next_s.awake = 1'b1;
        next_s.aref_ok = 1'b0;
        // Becoming awake forces a fresh inactivity reference
        next_s.iref_ok = 1'b0;
        next_s.inact_cnt = '0;
        if (link_on && s.autosleep)
          next_s.mode = mad_pkg::MAD_MEASURE;
      end
      else
        next_s.act_cnt = s.act_cnt + 8'h01;
    end

    next_s.irq = (next_s.st_act && next_s.act_int) ||
      (next_s.st_inact && next_s.inact_int);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s <= '0;
      s.odr <= mad_pkg::ODR_RST;
      s.act_time <= mad_pkg::ACT_TIME_RST;
      s.inact_time <= mad_pkg::INACT_TIME_RST;
    end
    else
      s <= next_s;
  end

  // Rate generator issues requests only outside standby
  assign o_smp_req = tick;
  assign o_wb_dat = s.rdat;
  assign o_wb_ack = s.ack;
  assign o_noise_mode = s.noise;
  assign o_range = s.range;
  assign o_awake = s.awake;
  assign o_int = s.irq;
endmodule

`default_nettype wire

/* File: bench/mad_fe_model.sv */
/*
  Sensor front end model: answers a sample request with one sample.
  Assumes the bench loads nx, ny, nz and sets arm before each sample.
*/
`default_nettype none

module mad_fe_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Request and sample
  input wire logic i_req,
  output logic o_valid,
  output logic signed [mad_pkg::SW-1:0] o_x,
  output logic signed [mad_pkg::SW-1:0] o_y,
  output logic signed [mad_pkg::SW-1:0] o_z
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [mad_pkg::SW-1:0] nx = 12'h000;
  logic signed [mad_pkg::SW-1:0] ny = 12'h000;
  logic signed [mad_pkg::SW-1:0] nz = 12'h000;
  logic arm = 1'b0;
  logic pend = 1'b0;
  logic fire;
  int dly = 0;

  initial
  begin
    o_valid = 1'b0;
    o_x = 12'h000;
    o_y = 12'h000;
    o_z = 12'h000;
  end

  assign fire = pend && dly == 0 && !i_rst;

  // Idle lines toggle so a stale value never passes for a fresh sample
  always @(posedge i_clk_sys)
  begin
    o_valid <= fire;
    o_x <= fire ? nx : ~o_x;
    o_y <= fire ? ny : ~o_y;
    o_z <= fire ? nz : ~o_z;
    if (i_rst || fire)
      pend <= 1'b0;
    else if (i_req && arm && !pend)
    begin
      pend <= 1'b1;
      dly <= $urandom_range(3, 0);
    end
    else if (pend)
      dly <= dly - 1;
    if (fire)
      arm <= 1'b0;
  end
endmodule

`default_nettype wire

/* File: bench/mad_top_props.sv */
/*
  Port-level assertions for the motion activity detector.
  Assumes it is bound to mad_top and sees only that module's ports.
*/
`default_nettype none

module mad_top_props (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Bus and status
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_smp_req,
  input wire logic i_smp_valid,
  input wire logic [1:0] o_noise_mode,
  input wire logic [1:0] o_range,
  input wire logic o_awake,
  input wire logic o_int
);
  logic written;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_clk_sys)
    if (i_rst)
      written <= 1'b0;
    else if (i_wb_cyc && i_wb_stb && i_wb_we)
      written <= 1'b1;

  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack next cycle");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  idle_data_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("data outside ack");
  quiet_reset_a: assert property (!written |-> !o_smp_req && !o_awake && !o_int)
    else $error("output before config");
  req_gap_a: assert property (o_smp_req |=> !o_smp_req [*3])
    else $error("requests too close");
  int_cause_a: assert property ($rose(o_int) |-> $past(i_smp_valid) ||
    $past(i_wb_cyc && i_wb_we))
    else $error("int without cause");
  awake_cause_a: assert property ($changed(o_awake) |-> $past(i_rst) ||
    $past(i_smp_valid))
    else $error("awake without sample");
  noise_cause_a: assert property ($changed(o_noise_mode) |->
    $past(i_rst) || $past(i_wb_cyc && i_wb_we))
    else $error("noise without write");
  range_cause_a: assert property ($changed(o_range) |->
    $past(i_rst) || $past(i_wb_cyc && i_wb_we))
    else $error("range without write");

  wake_seen_c: cover property (o_awake ##1 !o_awake);
  int_seen_c: cover property ($rose(o_int));
  req_seen_c: cover property (o_smp_req);
endmodule

bind mad_top mad_top_props u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_smp_req(o_smp_req), .i_smp_valid(i_smp_valid),
  .o_noise_mode(o_noise_mode), .o_range(o_range), .o_awake(o_awake),
  .o_int(o_int)
);

`default_nettype wire

/* File: bench/tb.sv */
/*
  Self-checking bench for the motion activity detector.
  Assumes shortened rate dividers and the front end model beside it.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 8;
  localparam int WDIV = 64;
  localparam logic [31:0] AE = 32'h1 << mad_pkg::CTRL_ACT_EN;
  localparam logic [31:0] AR = 32'h1 << mad_pkg::CTRL_ACT_REF;
  localparam logic [31:0] IE = 32'h1 << mad_pkg::CTRL_INACT_EN;
  localparam logic [31:0] LNK = 32'h1 << mad_pkg::CTRL_LINK;
  localparam logic [31:0] LOOP = 32'h2 << mad_pkg::CTRL_LINK;
  localparam logic [31:0] AS = 32'h1 << mad_pkg::CTRL_AUTOSLEEP;
  localparam logic [31:0] INTS = 32'h3 << mad_pkg::CTRL_ACT_INT;
  localparam logic [31:0] IR = 32'h1 << mad_pkg::CTRL_INACT_REF;
  localparam logic [7:0] ST = mad_pkg::ADR_STATUS;
  localparam logic [7:0] CT = mad_pkg::ADR_CTRL;
  logic i_clk_sys = 1'b0, i_rst = 1'b1;
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic o_wb_ack, o_smp_req, i_smp_valid, o_awake, o_int;
  logic signed [mad_pkg::SW-1:0] i_smp_x, i_smp_y, i_smp_z, sx;
  logic [1:0] o_noise_mode, o_range;
  int errors = 0, samples_checked = 0, cycles = 0, g;

  always #12.5 i_clk_sys = ~i_clk_sys;

  mad_top #(.P_DIV_ODR_MAX(DIV), .P_DIV_WAKE(WDIV)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_smp_req(o_smp_req), .i_smp_valid(i_smp_valid),
    .i_smp_x(i_smp_x), .i_smp_y(i_smp_y), .i_smp_z(i_smp_z),
    .o_noise_mode(o_noise_mode), .o_range(o_range), .o_awake(o_awake),
    .o_int(o_int));

  mad_fe_model fe (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(o_smp_req),
    .o_valid(i_smp_valid), .o_x(i_smp_x), .o_y(i_smp_y), .o_z(i_smp_z));

  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1 && ++n < 50);
    rd = o_wb_dat;
    if (n >= 50)
      errors++;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  function automatic logic signed [11:0] rnd(input int lo, input int hi);
    int v;
    v = $urandom_range(hi, lo);
    return 12'($urandom_range(1, 0) ? -v : v);
  endfunction

  function automatic logic [31:0] ctl(input int md, input int odr);
    return 32'(md) | (32'(odr) << mad_pkg::CTRL_ODR);
  endfunction

  // Front end answers only when armed, so no stale sample slips in
  task automatic smp(input logic signed [11:0] x, y, z);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    fe.nx = x;
    fe.ny = y;
    fe.nz = z;
    fe.arm = 1'b1;
    sx = x;
    do @(posedge i_clk_sys); while (i_smp_valid !== 1'b1 && ++n < 600);
    if (n >= 600)
      errors++;
    repeat (2) @(posedge i_clk_sys);
  endtask

  task automatic hit;
    smp(rnd(101, 2047), rnd(0, 100), rnd(0, 100));
  endtask

  task automatic calm;
    smp(rnd(0, 50), rnd(0, 50), rnd(0, 50));
  endtask

  task automatic gap(output int c);
    int n;
    n = 0;
    do @(posedge i_clk_sys); while (o_smp_req !== 1'b1 && ++n < 1000);
    c = 0;
    do begin @(posedge i_clk_sys); c++; end
      while (o_smp_req !== 1'b1 && c < 1000);
  endtask

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      errors++;
      give_verdict;
    end
  end

  initial
  begin
    void'($urandom(32'hC248E68B));
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rdchk("ctrl reset", CT, 32'h000000C0);
    rdchk("status reset", ST, 32'h0);
    rdchk("unmapped", 8'h24, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(CT, 32'((i << 2) | (i << 4)));
      @(negedge i_clk_sys);
      chk("noise", 32'(o_noise_mode), 32'(i < 3 ? i : 2));
      chk("range", 32'(o_range), 32'(i < 3 ? i : 2));
    end
    for (int o = 0; o < 6; o++)
    begin
      wr(CT, ctl(1, o));
      gap(g);
      chk("odr gap", 32'(g), 32'(DIV << (5 - o)));
    end
    wr(CT, ctl(2, 5));
    gap(g);
    chk("wake gap", 32'(g), 32'(WDIV));
    wr(CT, ctl(0, 5));
    repeat (2) @(posedge i_clk_sys);
    g = 0;
    repeat (300) @(posedge i_clk_sys) g += (o_smp_req === 1'b1);
    chk("standby req", 32'(g), 32'h0);
    wr(mad_pkg::ADR_ACT_THR, 32'h64);
    wr(mad_pkg::ADR_ACT_TIME, 32'h3);
    wr(mad_pkg::ADR_INACT_THR, 32'h32);
    wr(mad_pkg::ADR_INACT_TIME, 32'h2);
    wr(CT, ctl(1, 5) | AE | INTS);
    hit; hit; calm; hit; hit;
    rdchk("act restart", ST, 32'h8);
    hit;
    rdchk("act flag", ST, 32'hD);
    chk("act int", 32'(o_int), 32'h1);
    chk("awake", 32'(o_awake), 32'h1);
    rdchk("data x", mad_pkg::ADR_DATA_X, 32'(sx));
    wr(CT, ctl(0, 5) | AE | INTS);
    repeat (100) @(posedge i_clk_sys);
    rdchk("standby keep", ST, 32'hD);
    wr(ST, 32'h9);
    rdchk("clear", ST, 32'h4);
    wr(CT, ctl(1, 5) | IE | INTS);
    calm;
    rdchk("inact early", ST, 32'hC);
    calm;
    rdchk("inact flag", ST, 32'hA);
    chk("inact int", 32'(o_int), 32'h1);
    wr(ST, 32'hB);
    wr(mad_pkg::ADR_ACT_TIME, 32'h0);
    wr(CT, ctl(1, 5) | AE | AR);
    smp(12'h3E8, 12'h0, 12'h0);
    smp(12'h41A, 12'h0, 12'h0);
    rdchk("ref hold", ST, 32'h8);
    smp(12'h4B0, 12'h0, 12'h0);
    rdchk("ref act", ST, 32'hD);
    wr(ST, 32'hB);
    wr(mad_pkg::ADR_ACT_TIME, 32'h3);
    wr(CT, ctl(2, 5) | AE);
    hit;
    rdchk("wake act", ST, 32'hD);
    wr(ST, 32'hB);
    wr(CT, ctl(1, 5) | AE | IE | LOOP | AS);
    calm; calm;
    wb(1'b0, CT, 32'h0);
    chk("auto sleep", rd & 32'h3, 32'h2);
    hit;
    wb(1'b0, CT, 32'h0);
    chk("auto wake", rd & 32'h3, 32'h1);
    chk("loop awake", 32'(o_awake), 32'h1);
    wr(CT, ctl(1, 5) | AE | IE | LNK);
    wr(ST, 32'h2);
    calm; calm;
    wb(1'b0, ST, 32'h0);
    chk("linked hold", rd & 32'h2, 32'h0);
    wr(ST, 32'h1);
    calm; calm;
    wb(1'b0, ST, 32'h0);
    chk("linked arm", rd & 32'h2, 32'h2);
    // Absolute compare would never settle at 1 g; only a moved band does
    wr(ST, 32'hB);
    wr(CT, ctl(1, 5) | IE | IR);
    smp(12'h3E8, 12'h0, 12'h0);
    smp(12'h4B0, 12'h0, 12'h0);
    smp(12'h4CE, 12'h0, 12'h0);
    rdchk("iref move", ST, 32'h8);
    smp(12'h4D8, 12'h0, 12'h0);
    rdchk("iref sleep", ST, 32'hA);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rdchk("ctrl rereset", CT, 32'h000000C0);
    give_verdict;
  end
endmodule

`default_nettype wire
